// ---- hpc_pkg.sv ----
// Package with register map, field layout, timing counts and carrier types for the hub port config block
package hpc_pkg;

	// Register addresses on the local register port
	localparam logic [15:0] HPC_ADDR_CFG_TWO = 16'h00E5;
	localparam logic [15:0] HPC_ADDR_CFG_THREE = 16'h00E6;
	localparam logic [15:0] HPC_ADDR_FIXED_MASK = 16'h00E7;
	localparam logic [15:0] HPC_ADDR_DIS_SELF = 16'h300A;
	localparam logic [15:0] HPC_ADDR_DIS_BUS = 16'h300B;
	localparam logic [15:0] HPC_ADDR_MAP_ONE_TWO = 16'h30FB;
	localparam logic [15:0] HPC_ADDR_MAP_THREE = 16'h30FC;

	// Writable bit masks; everything else is reserved and reads zero
	localparam logic [7:0] HPC_WMASK_CFG_TWO = 8'h38;
	localparam logic [7:0] HPC_WMASK_CFG_THREE = 8'h08;
	localparam logic [7:0] HPC_WMASK_PORTS = 8'h0E;
	localparam logic [7:0] HPC_WMASK_MAP = 8'hFF;

	// Field positions
	localparam int HPC_OC_LSB = 4;
	localparam int HPC_COMPOUND_BIT = 3;
	localparam int HPC_RENUMBER_BIT = 3;
	localparam int HPC_NPORTS = 3;
	localparam int HPC_MAP_W = 4;

	// Reset values
	localparam logic [7:0] HPC_RST_CFG_TWO = 8'h00;
	localparam logic [7:0] HPC_RST_CFG_THREE = 8'h00;
	localparam logic [7:0] HPC_RST_FIXED_MASK = 8'h00;
	localparam logic [7:0] HPC_RST_DIS = 8'h00;
	localparam logic [7:0] HPC_RST_MAP = 8'h00;
	localparam logic [7:0] HPC_RD_ZERO = 8'h00;

	// Over-current filter delays in ns and their cycle counts, rounded up
	localparam int HPC_CLK_NS = 8;
	localparam int HPC_OC_NS_0 = 50;
	localparam int HPC_OC_NS_1 = 100;
	localparam int HPC_OC_NS_2 = 200;
	localparam int HPC_OC_NS_3 = 400;
	localparam int HPC_OC_CW = 6;
	localparam logic [5:0] HPC_OC_CNT_0 = 6'((HPC_OC_NS_0 + HPC_CLK_NS - 1) / HPC_CLK_NS);
	localparam logic [5:0] HPC_OC_CNT_1 = 6'((HPC_OC_NS_1 + HPC_CLK_NS - 1) / HPC_CLK_NS);
	localparam logic [5:0] HPC_OC_CNT_2 = 6'((HPC_OC_NS_2 + HPC_CLK_NS - 1) / HPC_CLK_NS);
	localparam logic [5:0] HPC_OC_CNT_3 = 6'((HPC_OC_NS_3 + HPC_CLK_NS - 1) / HPC_CLK_NS);
	localparam logic [5:0] HPC_CNT_ZERO = 6'h00;
	localparam logic [5:0] HPC_CNT_ONE = 6'h01;

	// Register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} hpc_req_t;

	// Over-current filter state
	typedef struct packed {
		logic [5:0] cnt;
		logic flt;
	} hpc_oc_t;

	// Main block state
	typedef struct packed {
		logic [7:0] cfg_two;
		logic [7:0] cfg_three;
		logic [7:0] fixed_mask;
		logic [7:0] dis_self;
		logic [7:0] dis_bus;
		logic [7:0] map_one_two;
		logic [7:0] map_three;
		logic [7:0] rdata;
		logic compound;
		logic [3:1] fixed_rep;
		logic [3:1] enabled;
		logic [11:0] port_num;
		logic [1:0] nports;
		logic renumber;
		logic [3:1] oc_rep;
	} hpc_state_t;

endpackage

// ---- hpc_oc_filter.sv ----
// Over-current filter for one downstream port with selectable delay
`timescale 1ns/1ns
`default_nettype none

module hpc_oc_filter (
	input wire logic clk,
	input wire logic rst,
	input wire logic oc_raw,
	input wire logic [1:0] delay_sel,
	output logic oc_flt
);

	hpc_pkg::hpc_oc_t s_q;
	hpc_pkg::hpc_oc_t s_d;
	logic [5:0] limit;

	// RULE1: delay code select
	always_comb begin
		case (delay_sel)
			2'h0: limit = hpc_pkg::HPC_OC_CNT_0;
			2'h1: limit = hpc_pkg::HPC_OC_CNT_1;
			2'h2: limit = hpc_pkg::HPC_OC_CNT_2;
			default: limit = hpc_pkg::HPC_OC_CNT_3;
		endcase
	end

	// Fault must persist for the whole delay; a glitch restarts the count
	always_comb begin
		s_d = s_q;
		if (!oc_raw) begin
			s_d.cnt = hpc_pkg::HPC_CNT_ZERO;
			s_d.flt = 1'b0;
		end else if (s_q.cnt < limit) begin
			s_d.cnt = s_q.cnt + hpc_pkg::HPC_CNT_ONE;
			s_d.flt = (s_q.cnt + hpc_pkg::HPC_CNT_ONE) >= limit;
		end else begin
			s_d.flt = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign oc_flt = s_q.flt;

endmodule // hpc_oc_filter

`default_nettype wire

// ---- hpc_port_config.sv ----
// Hub port configuration bytes: register file, compound report, port numbering, fixed-device mask
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Contract
// RULE1: Delay code picks over-current filter delay
// RULE2: Compound bit drives compound-device report
// RULE3: Compound configs must also mark fixed ports; outside strap mode not enforced, compound follows cfg_two bit 3 alone
// RULE4: Strap mode: any fixed port means compound
// RULE5: Byte three bit selects numbering method
// RULE6: Standard mode numbers enabled ports contiguously
// RULE7: Standard mode enables from straps or disables
// RULE8: Remap mode takes numbers from remap registers
// RULE9: Mask bits one to three map ports
// RULE10: Report fixed devices on active ports only
// RULE11: Strap mode uses fixed-device strap pins
// RULE12: Firmware sets port one fixed bit
// RULE13: Reserved bits read zero, writes ignored
module hpc_port_config (
	input wire logic clk,
	input wire logic rst,
	input wire hpc_pkg::hpc_req_t req,
	output logic [7:0] rdata,
	input wire logic strap_mode,
	input wire logic self_powered,
	input wire logic [1:0] fixed_device_strap_pins,
	input wire logic [1:0] port_disable_strap_pins,
	input wire logic [3:1] oc_raw,
	output logic [3:1] oc_filtered,
	output logic compound_report,
	output logic [3:1] fixed_port_report,
	output logic [3:1] port_enabled,
	output logic [11:0] port_number,
	output logic [1:0] active_port_count,
	output logic port_renumber_mode
);

	hpc_pkg::hpc_state_t s_q;
	hpc_pkg::hpc_state_t s_d;
	logic [3:1] oc_flt;

	// Per-port over-current filters share the delay field
	genvar gi;
	generate
		for (gi = 1; gi <= hpc_pkg::HPC_NPORTS; gi++) begin : g_oc
			// RULE1: per-port filter delay
			hpc_oc_filter u_flt (
				.clk(clk),
				.rst(rst),
				.oc_raw(oc_raw[gi]),
				.delay_sel(s_q.cfg_two[hpc_pkg::HPC_OC_LSB +: 2]),
				.oc_flt(oc_flt[gi])
			);
		end
	endgenerate

	// Strap codes expand to port sets starting at port one
	function automatic logic [3:1] strap_ports(input logic [1:0] code);
		case (code)
			2'h0: strap_ports = 3'h0;
			2'h1: strap_ports = 3'h1;
			2'h2: strap_ports = 3'h3;
			default: strap_ports = 3'h7;
		endcase
	endfunction

	// Register file, derived reports and read path
	always_comb begin
		logic [3:1] dis;
		logic [3:1] fixed;
		logic [1:0] n;
		dis = 3'h0;
		fixed = 3'h0;
		n = 2'h0;
		s_d = s_q;

		// RULE13: masked writes
		if (req.we) begin
			case (req.addr)
				hpc_pkg::HPC_ADDR_CFG_TWO: s_d.cfg_two = req.wdata & hpc_pkg::HPC_WMASK_CFG_TWO;
				hpc_pkg::HPC_ADDR_CFG_THREE: s_d.cfg_three = req.wdata & hpc_pkg::HPC_WMASK_CFG_THREE;
				hpc_pkg::HPC_ADDR_FIXED_MASK: s_d.fixed_mask = req.wdata & hpc_pkg::HPC_WMASK_PORTS;
				hpc_pkg::HPC_ADDR_DIS_SELF: s_d.dis_self = req.wdata & hpc_pkg::HPC_WMASK_PORTS;
				hpc_pkg::HPC_ADDR_DIS_BUS: s_d.dis_bus = req.wdata & hpc_pkg::HPC_WMASK_PORTS;
				hpc_pkg::HPC_ADDR_MAP_ONE_TWO: s_d.map_one_two = req.wdata & hpc_pkg::HPC_WMASK_MAP;
				hpc_pkg::HPC_ADDR_MAP_THREE: s_d.map_three = req.wdata & hpc_pkg::HPC_WMASK_MAP;
				default: ;
			endcase
		end

		// Read data stands for one cycle only; unmapped reads give zero
		s_d.rdata = hpc_pkg::HPC_RD_ZERO;
		if (req.re) begin
			case (req.addr)
				hpc_pkg::HPC_ADDR_CFG_TWO: s_d.rdata = s_q.cfg_two;
				hpc_pkg::HPC_ADDR_CFG_THREE: s_d.rdata = s_q.cfg_three;
				hpc_pkg::HPC_ADDR_FIXED_MASK: s_d.rdata = s_q.fixed_mask;
				hpc_pkg::HPC_ADDR_DIS_SELF: s_d.rdata = s_q.dis_self;
				hpc_pkg::HPC_ADDR_DIS_BUS: s_d.rdata = s_q.dis_bus;
				hpc_pkg::HPC_ADDR_MAP_ONE_TWO: s_d.rdata = s_q.map_one_two;
				hpc_pkg::HPC_ADDR_MAP_THREE: s_d.rdata = s_q.map_three;
				default: s_d.rdata = hpc_pkg::HPC_RD_ZERO;
			endcase
		end

		// RULE7: enable source
		if (strap_mode) begin
			dis = strap_ports(port_disable_strap_pins);
		end else if (self_powered) begin
			dis = s_q.dis_self[3:1];
		end else begin
			dis = s_q.dis_bus[3:1];
		end
		s_d.enabled = ~dis;

		// RULE11: strap pins replace mask
		// RULE9: bits one to three
		if (strap_mode) begin
			fixed = strap_ports(fixed_device_strap_pins);
		end else begin
			fixed = s_q.fixed_mask[3:1];
		end
		// RULE10: active ports only
		s_d.fixed_rep = fixed & ~dis;

		// RULE4: strap implies compound
		// RULE2: compound bit report
		if (strap_mode) begin
			s_d.compound = |fixed;
		end else begin
			s_d.compound = s_q.cfg_two[hpc_pkg::HPC_COMPOUND_BIT];
		end

		// RULE5: numbering method select
		s_d.renumber = strap_mode ? 1'b0 : s_q.cfg_three[hpc_pkg::HPC_RENUMBER_BIT];

		// RULE6: contiguous standard numbering
		for (int p = 1; p <= hpc_pkg::HPC_NPORTS; p++) begin
			if (!dis[p]) begin
				n = n + 2'h1;
			end
			s_d.port_num[(p - 1) * hpc_pkg::HPC_MAP_W +: hpc_pkg::HPC_MAP_W] = dis[p] ? 4'h0 : {2'h0, n};
		end
		s_d.nports = n;

		// RULE8: remap register numbers
		if (s_d.renumber) begin
			s_d.port_num = {s_q.map_three[3:0], s_q.map_one_two};
		end

		// Filtered over-current gets its own output flop
		s_d.oc_rep = oc_flt;
	end

	// State register; configuration reset values are fixed constants
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q.cfg_two <= hpc_pkg::HPC_RST_CFG_TWO;
			s_q.cfg_three <= hpc_pkg::HPC_RST_CFG_THREE;
			s_q.fixed_mask <= hpc_pkg::HPC_RST_FIXED_MASK;
			s_q.dis_self <= hpc_pkg::HPC_RST_DIS;
			s_q.dis_bus <= hpc_pkg::HPC_RST_DIS;
			s_q.map_one_two <= hpc_pkg::HPC_RST_MAP;
			s_q.map_three <= hpc_pkg::HPC_RST_MAP;
			s_q.rdata <= hpc_pkg::HPC_RD_ZERO;
			s_q.compound <= 1'b0;
			s_q.fixed_rep <= 3'h0;
			s_q.enabled <= 3'h0;
			s_q.port_num <= 12'h000;
			s_q.nports <= 2'h0;
			s_q.renumber <= 1'b0;
			s_q.oc_rep <= 3'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign rdata = s_q.rdata;
	assign oc_filtered = s_q.oc_rep;
	assign compound_report = s_q.compound;
	assign fixed_port_report = s_q.fixed_rep;
	assign port_enabled = s_q.enabled;
	assign port_number = s_q.port_num;
	assign active_port_count = s_q.nports;
	assign port_renumber_mode = s_q.renumber;

endmodule // hpc_port_config

`default_nettype wire

// ---- hpc_port_config_chk.sv ----
// Checker for the hub port config ports
`timescale 1ns/1ns
`default_nettype none
module hpc_port_config_chk (
	input wire logic clk,
	input wire logic rst,
	input wire hpc_pkg::hpc_req_t req,
	input wire logic [7:0] rdata,
	input wire logic strap_mode,
	input wire logic [1:0] fixed_device_strap_pins,
	input wire logic [3:1] oc_raw,
	input wire logic [3:1] oc_filtered,
	input wire logic compound_report,
	input wire logic [3:1] fixed_port_report,
	input wire logic [3:1] port_enabled,
	input wire logic [1:0] active_port_count,
	input wire logic port_renumber_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Read data and reserved bits
	chk_rdata_idle: assert property (!$past(req.re) |-> rdata == 8'h00)
		else $error("rdata not idle");
	chk_resv_three: assert property ($past(req.re) && $past(req.addr) == 16'h00E6 |-> (rdata & 8'hF7) == 8'h00)
		else $error("reserved bits set");
	// Port reports stay consistent
	chk_fixed_active: assert property ((fixed_port_report & ~port_enabled) == 3'h0)
		else $error("fixed on idle port");
	chk_port_count: assert property (active_port_count == 2'($countones(port_enabled)))
		else $error("port count wrong");
	// Strap mode: compound follows fixed pins, numbering stays standard
	chk_strap_compound: assert property (!$past(rst) && $past(strap_mode)
		|-> compound_report == ($past(fixed_device_strap_pins) != 2'h0))
		else $error("strap compound wrong");
	chk_strap_std: assert property (!$past(rst) && $past(strap_mode) |-> !port_renumber_mode)
		else $error("remap in strap mode");
	// Filter never passes short pulses and releases promptly
	chk_oc_hold: assert property ($rose(oc_raw[1]) |-> !oc_filtered[1] [*7])
		else $error("filter too fast");
	chk_oc_fall: assert property ($fell(oc_raw[1]) |-> ##2 !oc_filtered[1])
		else $error("filter release late");
	cover property (strap_mode && compound_report);
	cover property ($rose(oc_filtered[1]));
	cover property (port_renumber_mode);
endmodule // hpc_port_config_chk
bind hpc_port_config hpc_port_config_chk u_chk (.clk, .rst, .req, .rdata, .strap_mode, .fixed_device_strap_pins,
	.oc_raw, .oc_filtered, .compound_report, .fixed_port_report, .port_enabled, .active_port_count, .port_renumber_mode);
`default_nettype wire

// ---- hpc_port_config_tb.sv ----
// Testbench for the hub port config block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module hpc_port_config_tb;
	logic clk, rst, strap_mode, self_powered, compound_report, port_renumber_mode;
	logic [1:0] fixed_device_strap_pins, port_disable_strap_pins, active_port_count;
	logic [3:1] oc_raw, oc_filtered, fixed_port_report, port_enabled;
	logic [7:0] rdata, d;
	logic [11:0] port_number;
	hpc_pkg::hpc_req_t req;
	int n_fail = 0, total_checks = 0;
	logic [15:0] ad [7] = '{16'h00E5, 16'h00E6, 16'h00E7, 16'h300A, 16'h300B, 16'h30FB, 16'h30FC};
	logic [7:0] wm [7] = '{8'h38, 8'h08, 8'h0E, 8'h0E, 8'h0E, 8'hFF, 8'hFF};
	hpc_port_config u_dut (.clk, .rst, .req, .rdata, .strap_mode, .self_powered, .fixed_device_strap_pins,
		.port_disable_strap_pins, .oc_raw, .oc_filtered, .compound_report, .fixed_port_report, .port_enabled,
		.port_number, .active_port_count, .port_renumber_mode);
	// Free running clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// Bus cycles; derived outputs need two cycles after a write
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		req.we <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req.re <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic t_regs;
		for (int i = 0; i < 7; i++) begin
			rd(ad[i]);
			`CHK(d, 8'h00)
			wr(ad[i], 8'hFF);
			rd(ad[i]);
			`CHK(d, wm[i])
		end
		wr(16'h0100, 8'hFF);
		rd(16'h0100);
		`CHK(d, 8'h00)
		for (int i = 0; i < 7; i++) wr(ad[i], 8'h00);
	endtask
	task automatic t_numbers;
		self_powered <= 1'b1;
		wr(16'h00E7, 8'h0E);
		wr(16'h300A, 8'h04);
		settle;
		`CHK(port_enabled, 3'h5)
		`CHK(port_number, 12'h201)
		`CHK(fixed_port_report, 3'h5)
		`CHK(active_port_count, 2'h2)
		@(posedge clk);
		self_powered <= 1'b0;
		wr(16'h300B, 8'h08);
		settle;
		`CHK(port_number, 12'h021)
		wr(16'h30FB, 8'h21);
		wr(16'h30FC, 8'h03);
		wr(16'h00E6, 8'h08);
		settle;
		`CHK(port_renumber_mode, 1'b1)
		`CHK(port_number, 12'h321)
		wr(16'h00E6, 8'h00);
		wr(16'h00E7, 8'h02);
		wr(16'h00E5, 8'h08);
		settle;
		`CHK(compound_report, 1'b1)
		`CHK(fixed_port_report, 3'h1)
		wr(16'h00E5, 8'h00);
		settle;
		`CHK(compound_report, 1'b0)
	endtask
	task automatic t_straps;
		logic [3:1] fx [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
		@(posedge clk);
		strap_mode <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			fixed_device_strap_pins <= 2'(c);
			settle;
			`CHK(compound_report, c != 0)
			`CHK(fixed_port_report, fx[c])
		end
		@(posedge clk);
		port_disable_strap_pins <= 2'h2;
		settle;
		`CHK(port_number, 12'h100)
		`CHK(fixed_port_report, 3'h4)
		@(posedge clk);
		strap_mode <= 1'b0;
	endtask
	task automatic t_oc;
		int n;
		for (int c = 0; c < 4; c++) begin
			wr(16'h00E5, 8'(c << 4));
			settle;
			@(posedge clk);
			oc_raw <= 3'h7;
			n = 0;
			do begin
				@(posedge clk);
				#1 n++;
			end while (oc_filtered !== 3'h7 && n < 80);
			`CHK(n, ((50 << c) + 7) / 8 + 1)
			@(posedge clk);
			oc_raw <= 3'h0;
			settle;
			`CHK(oc_filtered, 3'h0)
		end
	endtask
	// Mid-run reset clears registers and the compound report; all ports come back enabled
	task automatic t_reset;
		wr(16'h00E5, 8'hFF);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		rd(16'h00E5);
		`CHK(d, 8'h00)
		settle;
		`CHK(compound_report, 1'b0)
		`CHK(port_enabled, 3'h7)
	endtask
	task automatic finish_test;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog well beyond the few hundred cycles needed
	initial begin
		#100000;
		n_fail++;
		finish_test;
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		req = '0;
		strap_mode = 1'b0;
		self_powered = 1'b0;
		fixed_device_strap_pins = 2'h0;
		port_disable_strap_pins = 2'h0;
		oc_raw = 3'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_numbers;
		t_straps;
		t_oc;
		t_reset;
		finish_test;
	end
endmodule // hpc_port_config_tb
`default_nettype wire
